/* pkg/mmd_pkg.sv */
// Overview of operation
// - Indirect upper addresses reach upper RAM bytes.
// - Direct upper addresses reach special function space.
// - Lower RAM same location, direct or indirect.
// - First 32 bytes form four register banks.
// - Next 16 bytes allow byte and bit access.
// - Program memory is 32k main plus 128 extra.
// - Erase by 512-byte sectors, no external voltage.
// - Range 0x7e00 to 0x7fff reserved factory area.
// - Extra 128-byte sector at 0x8000 to 0x807f.
package mmd_pkg;
  localparam int unsigned DATA_AW = 8;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] BANK_END = 8'h1f;
  localparam logic [7:0] BITB_BASE = 8'h20;
  localparam logic [7:0] BITB_END = 8'h2f;
  localparam int unsigned BANK_SHIFT = 3;
  localparam int unsigned PROG_AW = 16;
  localparam logic [15:0] MAIN_END = 16'h7fff;
  localparam logic [15:0] RSVD_BASE = 16'h7e00;
  localparam logic [15:0] RSVD_END = 16'h7fff;
  localparam logic [15:0] EXTRA_BASE = 16'h8000;
  localparam logic [15:0] EXTRA_END = 16'h807f;
  localparam int unsigned SECTOR_SHIFT = 9;

  // Data space target encoding.
  typedef enum logic [3:0] {
    MMD_T_NONE = 4'h0,
    MMD_T_RAM = 4'h1,
    MMD_T_SFS = 4'h2,
    MMD_T_BIT = 4'h4
  } mmd_tgt_t;

  // Data access request from the core.
  typedef struct packed {
    logic valid;
    logic indirect;
    logic bit_acc;
    logic reg_ref;
    logic [7:0] addr;
    logic [1:0] bank_sel;
  } mmd_dreq_t;

  // Decoded data access.
  typedef struct packed {
    logic valid;
    mmd_tgt_t tgt;
    logic [7:0] ram_addr;
    logic [6:0] sfs_addr;
    logic [2:0] bit_pos;
  } mmd_dres_t;

  // Program space decode.
  typedef struct packed {
    logic valid;
    logic main_hit;
    logic extra_hit;
    logic reserved;
    logic unmapped;
    logic [6:0] sector;
    logic [15:0] addr;
  } mmd_pres_t;
endpackage : mmd_pkg

/* design/mmd_prog_dec.sv */
`timescale 1ns/100ps
// Combinational program-space decoder.
module mmd_prog_dec (
  input wire logic [15:0] addr_i,
  input wire logic user_wr_i,
  output logic main_hit_o,
  output logic extra_hit_o,
  output logic reserved_o,
  output logic unmapped_o,
  output logic [6:0] sector_o
);
  // Reserved area is kept from user writes; reads still see the main array.
  always_comb begin
    main_hit_o = (addr_i <= mmd_pkg::MAIN_END) &&
      !(user_wr_i && addr_i >= mmd_pkg::RSVD_BASE);
    reserved_o = (addr_i >= mmd_pkg::RSVD_BASE) && (addr_i <= mmd_pkg::RSVD_END);
    extra_hit_o = (addr_i >= mmd_pkg::EXTRA_BASE) && (addr_i <= mmd_pkg::EXTRA_END);
    unmapped_o = !(addr_i <= mmd_pkg::MAIN_END) && !extra_hit_o;
    sector_o = addr_i[15:mmd_pkg::SECTOR_SHIFT];
  end
endmodule : mmd_prog_dec

/* design/mmd_decoder.sv */
`timescale 1ns/100ps
// Registered memory map decoder: one cycle from request to result.
module mmd_decoder (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire mmd_pkg::mmd_dreq_t dreq_i,
  input wire logic preq_valid_i,
  input wire logic preq_wr_i,
  input wire logic [15:0] preq_addr_i,
  output mmd_pkg::mmd_dres_t dres_o,
  output mmd_pkg::mmd_pres_t pres_o
);
  typedef struct packed {
    logic [1:0] rst_sync;
    mmd_pkg::mmd_dres_t dres;
    mmd_pkg::mmd_pres_t pres;
  } mmd_state_t;

  mmd_state_t state_q;
  mmd_state_t state_d;
  logic rst_n;
  logic main_hit, extra_hit, reserved, unmapped;
  logic [6:0] sector;

  // Reset release passes two flops so all state leaves reset on one edge.
  assign rst_n = state_q.rst_sync[1];

  mmd_prog_dec u_prog (
    .addr_i(preq_addr_i),
    .user_wr_i(preq_wr_i),
    .main_hit_o(main_hit),
    .extra_hit_o(extra_hit),
    .reserved_o(reserved),
    .unmapped_o(unmapped),
    .sector_o(sector)
  );

  // Bit address to byte and bit position, eight bits per byte, LSB first.
  function automatic logic [7:0] bit_byte(input logic [6:0] b);
    bit_byte = mmd_pkg::BITB_BASE + {4'h0, b[6:3]};
  endfunction : bit_byte

  // Decode the data access; upper half splits on addressing mode.
  always_comb begin
    state_d = state_q;
    state_d.rst_sync = {state_q.rst_sync[0], 1'b1};
    state_d.dres = '0;
    state_d.pres = '0;
    state_d.dres.valid = dreq_i.valid;
    if (dreq_i.valid) begin
      if (dreq_i.reg_ref) begin
        // Register reference: bank offset of eight bytes per bank.
        state_d.dres.tgt = mmd_pkg::MMD_T_RAM;
        state_d.dres.ram_addr = {3'h0, dreq_i.bank_sel, dreq_i.addr[2:0]};
      end else if (dreq_i.bit_acc) begin
        if (dreq_i.addr[7]) begin
          state_d.dres.tgt = mmd_pkg::MMD_T_SFS;
          state_d.dres.sfs_addr = {dreq_i.addr[6:3], 3'h0};
        end else begin
          state_d.dres.tgt = mmd_pkg::MMD_T_BIT;
          state_d.dres.ram_addr = bit_byte(dreq_i.addr[6:0]);
        end
        state_d.dres.bit_pos = dreq_i.addr[2:0];
      end else if (dreq_i.addr >= mmd_pkg::UPPER_BASE && !dreq_i.indirect) begin
        state_d.dres.tgt = mmd_pkg::MMD_T_SFS;
        state_d.dres.sfs_addr = dreq_i.addr[6:0];
      end else begin
        state_d.dres.tgt = mmd_pkg::MMD_T_RAM;
        state_d.dres.ram_addr = dreq_i.addr;
      end
    end
    state_d.pres.valid = preq_valid_i;
    if (preq_valid_i) begin
      state_d.pres.main_hit = main_hit;
      state_d.pres.extra_hit = extra_hit;
      state_d.pres.reserved = reserved;
      state_d.pres.unmapped = unmapped;
      state_d.pres.sector = sector;
      state_d.pres.addr = preq_addr_i;
    end
    // Results stay clear until the synchronised reset releases.
    if (!rst_n) begin
      state_d.dres = '0;
      state_d.pres = '0;
    end
  end

  // All state in one register; the asynchronous branch loads constants only.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign dres_o = state_q.dres;
  assign pres_o = state_q.pres;

  // While the synchronised reset holds, both results read as all zeros.
  property p_reset_clear;
    @(posedge clock_i)
    !rst_n |-> dres_o == '0 && pres_o == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("result not clear in reset");
  // A data request yields a valid result on the next edge, and silence yields zeros.
  property p_dvalid;
    @(posedge clock_i) disable iff (!rst_n)
    dreq_i.valid |=> dres_o.valid;
  endproperty
  a_dvalid: assert property (p_dvalid) else $error("data result not flagged valid");
  property p_didle;
    @(posedge clock_i) disable iff (!rst_n)
    !dreq_i.valid |=> dres_o == '0;
  endproperty
  a_didle: assert property (p_didle) else $error("idle data result not clear");
  // Direct access to the upper half goes to special function space, same offset.
  property p_upper_direct;
    @(posedge clock_i) disable iff (!rst_n)
    dreq_i.valid && !dreq_i.indirect && !dreq_i.bit_acc && !dreq_i.reg_ref && dreq_i.addr[7]
    |=> dres_o.tgt == mmd_pkg::MMD_T_SFS;
  endproperty
  a_upper_direct: assert property (p_upper_direct) else $error("upper direct missed");
  property p_upper_dir_addr;
    @(posedge clock_i) disable iff (!rst_n)
    dreq_i.valid && !dreq_i.indirect && !dreq_i.bit_acc && !dreq_i.reg_ref && dreq_i.addr[7]
    |=> dres_o.sfs_addr == $past(dreq_i.addr[6:0]);
  endproperty
  a_upper_dir_addr: assert property (p_upper_dir_addr) else $error("offset wrong");
  property p_upper_ind;
    @(posedge clock_i) disable iff (!rst_n)
    dreq_i.valid && dreq_i.indirect && !dreq_i.bit_acc && !dreq_i.reg_ref
    |=> dres_o.tgt == mmd_pkg::MMD_T_RAM && dres_o.ram_addr == $past(dreq_i.addr);
  endproperty
  a_upper_ind: assert property (p_upper_ind) else $error("indirect access not to RAM");
  property p_lower_same;
    @(posedge clock_i) disable iff (!rst_n)
    dreq_i.valid && !dreq_i.bit_acc && !dreq_i.reg_ref && !dreq_i.addr[7]
    |=> dres_o.tgt == mmd_pkg::MMD_T_RAM && dres_o.ram_addr == $past(dreq_i.addr);
  endproperty
  a_lower_same: assert property (p_lower_same) else $error("lower RAM mismatch");
  property p_bank;
    @(posedge clock_i) disable iff (!rst_n)
    dreq_i.valid && dreq_i.reg_ref
    |=> dres_o.ram_addr == 8'(($past(dreq_i.bank_sel) * 8) + $past(dreq_i.addr[2:0]))
      && dres_o.ram_addr <= mmd_pkg::BANK_END;
  endproperty
  a_bank: assert property (p_bank) else $error("bank offset wrong");
  property p_bank_sel;
    @(posedge clock_i) disable iff (!rst_n)
    dreq_i.valid && dreq_i.reg_ref |=> dres_o.ram_addr[4:3] == $past(dreq_i.bank_sel);
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("bank selector ignored");
  property p_bitmap;
    @(posedge clock_i) disable iff (!rst_n)
    dreq_i.valid && dreq_i.bit_acc && !dreq_i.reg_ref && !dreq_i.addr[7]
    |=> dres_o.tgt == mmd_pkg::MMD_T_BIT && dres_o.ram_addr >= mmd_pkg::BITB_BASE
      && dres_o.ram_addr <= mmd_pkg::BITB_END && dres_o.bit_pos == $past(dreq_i.addr[2:0]);
  endproperty
  a_bitmap: assert property (p_bitmap) else $error("bit address mapping wrong");
  // Byte index of a bit address counts up from the start of the bit area.
  property p_bit_byte;
    @(posedge clock_i) disable iff (!rst_n)
    dreq_i.valid && dreq_i.bit_acc && !dreq_i.reg_ref && !dreq_i.addr[7]
    |=> dres_o.ram_addr == mmd_pkg::BITB_BASE + 8'($past(dreq_i.addr[6:3]));
  endproperty
  a_bit_byte: assert property (p_bit_byte) else $error("bit byte index wrong");
  // Upper bit addresses land on the eight-aligned special function location.
  property p_bit_sfs;
    @(posedge clock_i) disable iff (!rst_n)
    dreq_i.valid && dreq_i.bit_acc && !dreq_i.reg_ref && dreq_i.addr[7]
    |=> dres_o.tgt == mmd_pkg::MMD_T_SFS && dres_o.sfs_addr == {$past(dreq_i.addr[6:3]), 3'h0}
      && dres_o.bit_pos == $past(dreq_i.addr[2:0]);
  endproperty
  a_bit_sfs: assert property (p_bit_sfs) else $error("upper bit address wrong");
  property p_rsvd;
    @(posedge clock_i) disable iff (!rst_n)
    preq_valid_i && preq_wr_i && preq_addr_i >= 16'h7e00 && preq_addr_i <= 16'h7fff
    |=> pres_o.reserved && !pres_o.main_hit;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved range writable");
  // Reads of the factory range still reach the main array.
  property p_rsvd_read;
    @(posedge clock_i) disable iff (!rst_n)
    preq_valid_i && !preq_wr_i && preq_addr_i >= mmd_pkg::RSVD_BASE
      && preq_addr_i <= mmd_pkg::RSVD_END |=> pres_o.reserved && pres_o.main_hit;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read wrong");
  property p_extra;
    @(posedge clock_i) disable iff (!rst_n)
    preq_valid_i |=> pres_o.extra_hit == ($past(preq_addr_i) >= 16'h8000
      && $past(preq_addr_i) <= 16'h807f);
  endproperty
  a_extra: assert property (p_extra) else $error("extra sector decode wrong");
  property p_main;
    @(posedge clock_i) disable iff (!rst_n)
    preq_valid_i && !preq_wr_i |=> pres_o.main_hit == !$past(preq_addr_i[15]);
  endproperty
  a_main: assert property (p_main) else $error("main array decode wrong");
  property p_sector;
    @(posedge clock_i) disable iff (!rst_n)
    preq_valid_i |=> pres_o.sector == $past(preq_addr_i[15:9]);
  endproperty
  a_sector: assert property (p_sector) else $error("sector index wrong");
  // Addresses above the extra sector decode to nothing.
  property p_unmapped;
    @(posedge clock_i) disable iff (!rst_n)
    preq_valid_i |=> pres_o.unmapped == ($past(preq_addr_i) > mmd_pkg::EXTRA_END);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped decode wrong");
  // A program request is flagged valid and carries its address; silence is zeros.
  property p_pvalid;
    @(posedge clock_i) disable iff (!rst_n)
    preq_valid_i |=> pres_o.valid && pres_o.addr == $past(preq_addr_i);
  endproperty
  a_pvalid: assert property (p_pvalid) else $error("program result not valid");
  property p_pidle;
    @(posedge clock_i) disable iff (!rst_n)
    !preq_valid_i |=> pres_o == '0;
  endproperty
  a_pidle: assert property (p_pidle) else $error("idle program result not clear");
  // Main scenarios: the special function and bit data targets and each special program range.
  c_sfs: cover property (@(posedge clock_i) dres_o.tgt == mmd_pkg::MMD_T_SFS);
  c_bit: cover property (@(posedge clock_i) dres_o.tgt == mmd_pkg::MMD_T_BIT);
  c_rsvd: cover property (@(posedge clock_i) pres_o.reserved);
  c_extra: cover property (@(posedge clock_i) pres_o.extra_hit);
endmodule : mmd_decoder

/* dv/mmd_core_model.sv */
`timescale 1ns/100ps
// Core side model: issues one data and one program request per clock.
module mmd_core_model (
  input wire logic clock_i,
  output mmd_pkg::mmd_dreq_t dreq_o,
  output logic pv_o,
  output logic pw_o,
  output logic [15:0] pa_o
);
  // Idle levels until the first request, so nothing is decoded during reset.
  initial begin
    dreq_o = '0;
    pv_o = 1'b0;
    pw_o = 1'b0;
    pa_o = 16'h0000;
  end

  // A request changes just after an edge and holds for one whole cycle.
  task automatic issue(input mmd_pkg::mmd_dreq_t d, input logic v, input logic w,
      input logic [15:0] a);
    @(posedge clock_i);
    dreq_o <= d;
    pv_o <= v;
    pw_o <= w;
    pa_o <= a;
  endtask : issue
endmodule : mmd_core_model

/* dv/mcu_memory_map_decoder_tb_top.sv */
`timescale 1ns/100ps
// Decoder bench: corner and random requests, each answer checked one cycle later.
module mcu_memory_map_decoder_tb_top;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic armed = 1'b0;
  mmd_pkg::mmd_dreq_t dreq, seen_d, d;
  logic pv, pw, seen_v, seen_w;
  logic [15:0] pa, seen_a;
  mmd_pkg::mmd_dres_t dres;
  mmd_pkg::mmd_pres_t pres;
  logic [7:0] ca [10] = '{8'h00, 8'h1f, 8'h20, 8'h2f, 8'h30, 8'h7f, 8'h80, 8'h90, 8'hf8, 8'hff};
  logic [15:0] cp [10] = '{16'h0000, 16'h01ff, 16'h0200, 16'h7dff, 16'h7e00, 16'h7fff,
    16'h8000, 16'h807f, 16'h8080, 16'hffff};
  int n_mismatch = 0;
  int comparisons = 0;

  // The clock runs at 40 MHz.
  initial forever #12.5 clock_i = ~clock_i;

  mmd_core_model i_core (.clock_i(clock_i), .dreq_o(dreq), .pv_o(pv), .pw_o(pw), .pa_o(pa));
  mmd_decoder i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .dreq_i(dreq),
    .preq_valid_i(pv), .preq_wr_i(pw), .preq_addr_i(pa), .dres_o(dres), .pres_o(pres));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Program decode compare, the whole result at once.
  task automatic chk_prog(input string what, input mmd_pkg::mmd_pres_t exp,
      input mmd_pkg::mmd_pres_t got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_prog

  // Expected data decode; register references win over bit access, as chosen.
  function automatic mmd_pkg::mmd_dres_t exp_data(input mmd_pkg::mmd_dreq_t r);
    mmd_pkg::mmd_dres_t e;
    e = '0;
    e.valid = r.valid;
    e.tgt = mmd_pkg::MMD_T_RAM;
    e.ram_addr = r.addr;
    if (r.reg_ref) begin
      e.ram_addr = {3'h0, r.bank_sel, r.addr[2:0]};
    end else if (r.bit_acc && !r.addr[7]) begin
      e.tgt = mmd_pkg::MMD_T_BIT;
      e.ram_addr = mmd_pkg::BITB_BASE + {4'h0, r.addr[6:3]};
      e.bit_pos = r.addr[2:0];
    end else if (r.bit_acc) begin
      e.tgt = mmd_pkg::MMD_T_SFS;
      e.sfs_addr = {r.addr[6:3], 3'h0};
      e.bit_pos = r.addr[2:0];
    end else if (r.addr[7] && !r.indirect) begin
      e.tgt = mmd_pkg::MMD_T_SFS;
      e.sfs_addr = r.addr[6:0];
    end
    return e;
  endfunction : exp_data

  // Expected program decode; a user write never lands in the factory range.
  function automatic mmd_pkg::mmd_pres_t exp_prog(input logic v, input logic w,
      input logic [15:0] a);
    mmd_pkg::mmd_pres_t e;
    e.valid = v;
    e.reserved = a >= 16'h7e00 && a <= 16'h7fff;
    e.main_hit = a <= 16'h7fff && !(e.reserved && w);
    e.extra_hit = a >= 16'h8000 && a <= 16'h807f;
    e.unmapped = a > 16'h807f;
    e.sector = a[15:9];
    e.addr = a;
    return e;
  endfunction : exp_prog

  // Capture what the decoder sampled; the old values are read before the new ones land.
  always @(posedge clock_i) begin
    seen_d <= dreq;
    seen_v <= pv;
    seen_w <= pw;
    seen_a <= pa;
  end

  // Results are settled by the falling edge, half a cycle after they change.
  always @(negedge clock_i) begin
    mmd_pkg::mmd_dres_t e;
    e = exp_data(seen_d);
    if (armed) begin
      chk("data valid", 32'(e.valid), 32'(dres.valid));
      chk("prog valid", 32'(seen_v), 32'(pres.valid));
      if (e.valid) begin
        chk("data target", 32'(e.tgt), 32'(dres.tgt));
        if (e.tgt == mmd_pkg::MMD_T_SFS)
          chk("sfs addr", 32'(e.sfs_addr), 32'(dres.sfs_addr));
        else
          chk("ram addr", 32'(e.ram_addr), 32'(dres.ram_addr));
        if (seen_d.bit_acc && !seen_d.reg_ref)
          chk("bit pos", 32'(e.bit_pos), 32'(dres.bit_pos));
      end
      if (seen_v)
        chk_prog("prog decode", exp_prog(seen_v, seen_w, seen_a), pres);
    end
  end

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // Every corner address in each mix of direct/indirect and byte/bit access; write intent follows the indirect flag.
  task automatic run_corners();
    foreach (ca[i]) for (int k = 0; k < 4; k++) begin
      i_core.issue('{1'b1, k[0], k[1], 1'b0, ca[i], 2'h0}, 1'b1, k[0], cp[i]);
    end
  endtask : run_corners

  // Corner addresses in each direct/indirect and byte/bit mode, then all banks, then random traffic.
  initial begin
    void'($urandom(32'heca4));
    repeat (10) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    armed <= 1'b1;
    run_corners();
    for (int k = 0; k < 32; k++) begin
      i_core.issue('{1'b1, 1'b0, 1'b1, 1'b1, {5'h0, k[2:0]}, k[4:3]}, 1'b0, 1'b0, 16'h0);
    end
    for (int k = 0; k < 400; k++) begin
      d = 14'($urandom);
      i_core.issue(d, 1'($urandom), 1'($urandom), 16'($urandom));
    end
    // Mid-run reset: both results clear at once; decode resumes on the third edge.
    @(posedge clock_i);
    armed <= 1'b0;
    rst_b_i <= 1'b0;
    @(negedge clock_i);
    chk("reset data", 32'h0, 32'(dres));
    chk_prog("reset prog", '0, pres);
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    armed <= 1'b1;
    run_corners();
    i_core.issue('0, 1'b0, 1'b0, 16'h0);
    repeat (2) @(posedge clock_i);
    close_out();
  end

  // A hang is cut short well past the expected run of about 540 cycles.
  initial begin
    #(25 * 2000);
    n_mismatch++;
    close_out();
  end
endmodule : mcu_memory_map_decoder_tb_top
